// ---- inc/xra_consts.svh ----
`ifndef XRA_CONSTS_SVH
`define XRA_CONSTS_SVH
// default widths and memory depth
`define XRA_DW        32
`define XRA_OFFW      10
`define XRA_DEPTH     64
`define XRA_RATE_W    8
`define XRA_CNT_W     32
// soft register offsets inside one channel space
`define XRA_OFF_CAPID   11'h200
`define XRA_OFF_CAPCFG  11'h201
`define XRA_OFF_USERID  11'h202
`define XRA_OFF_STATUS  11'h210
`define XRA_OFF_CTRL    11'h211
`define XRA_OFF_RATE    11'h220
`define XRA_OFF_PRBSCTL 11'h230
`define XRA_OFF_PRBSBIT 11'h231
`define XRA_OFF_PRBSERR 11'h232
// control field bits
`define XRA_CTRL_LOOP   0
`define XRA_CTRL_FDATA  1
`define XRA_CTRL_FREF   2
`define XRA_CTRL_TXAR   3
`define XRA_CTRL_TXDR   4
`define XRA_CTRL_RXAR   5
`define XRA_CTRL_RXDR   6
`define XRA_CTRL_W      7
`define XRA_PRBS_CLR    0
// reset values
`define XRA_CTRL_RST    7'h00
`define XRA_RATE_RST    8'h00
// capability id, arbitrary value
`define XRA_CAP_ID      32'h0000_5A5A
`endif

// ---- inc/xra_pkg.sv ----
package xra_pkg;
  typedef enum logic [1:0] {
    XRA_IDLE,
    XRA_ACCESS,
    XRA_FETCH,
    XRA_REPLY
  } xra_port_state_t;
endpackage : xra_pkg

// ---- core/xra_chan.sv ----
`include "xra_consts.svh"
module xra_chan #(
  parameter int OFFW    = `XRA_OFFW,
  parameter int DW      = `XRA_DW,
  parameter int DEPTH   = `XRA_DEPTH,
  parameter int RATE_W  = `XRA_RATE_W,
  parameter int CNT_W   = `XRA_CNT_W,
  parameter int LANES   = 4,
  parameter int INDEX   = 0,
  parameter bit CAP_EN  = 1'b1,
  parameter bit CSR_EN  = 1'b1,
  parameter bit PRBS_EN = 1'b1,
  parameter logic [7:0] USER_ID = 8'h00
) (
  input  wire logic              clk,        // system clock
  input  wire logic              reset,      // sync reset
  input  wire logic              acc,        // one-cycle access strobe
  input  wire logic              wr,         // access is a write
  input  wire logic [OFFW-1:0]   off,        // register offset
  input  wire logic [DW-1:0]     wdata,      // write data
  output logic      [DW-1:0]     rdata,      // read data, next cycle
  input  wire logic [3:0]        status,     // lockRef, lockData, txCal, rxCal
  output logic [`XRA_CTRL_W-1:0] ctrl,       // control soft bits
  output logic      [RATE_W-1:0] laneRate,   // lane rate code
  input  wire logic              bitTick,    // checker bit counted
  input  wire logic              errTick     // checker error seen
);
  localparam int AW = $clog2(DEPTH);
  logic [DW-1:0]    mem [DEPTH];
  logic [CNT_W-1:0] bitCount;
  logic [CNT_W-1:0] errCount;
  logic             inMem;
  logic             prbsClr;

  assign inMem   = off < OFFW'(DEPTH);
  assign prbsClr = PRBS_EN && acc && wr && off == OFFW'(`XRA_OFF_PRBSCTL)
                   && wdata[`XRA_PRBS_CLR];

  // generic reconfiguration space
  always_ff @(posedge clk) begin
    if (acc && wr && inMem) begin
      mem[off[AW-1:0]] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl     <= `XRA_CTRL_RST;
      laneRate <= `XRA_RATE_RST;
    end else if (acc && wr) begin
      if (CSR_EN && off == OFFW'(`XRA_OFF_CTRL)) begin
        ctrl <= wdata[`XRA_CTRL_W-1:0];
      end
      if (off == OFFW'(`XRA_OFF_RATE)) begin
        laneRate <= wdata[RATE_W-1:0];
      end
    end
  end

  // saturating accumulators; a tick in the clear cycle still counts
  always_ff @(posedge clk) begin
    if (reset || !PRBS_EN) begin
      bitCount <= '0;
      errCount <= '0;
    end else begin
      if (prbsClr) begin
        bitCount <= CNT_W'(bitTick);
        errCount <= CNT_W'(errTick);
      end else begin
        if (bitTick && bitCount != '1) begin
          bitCount <= bitCount + 1'b1;
        end
        if (errTick && errCount != '1) begin
          errCount <= errCount + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= '0;
    end else if (acc && !wr) begin
      rdata <= '0;
      if (inMem) begin
        rdata <= mem[off[AW-1:0]];
      end else if (CAP_EN && off == OFFW'(`XRA_OFF_CAPID)) begin
        rdata <= DW'(`XRA_CAP_ID);
      end else if (CAP_EN && off == OFFW'(`XRA_OFF_CAPCFG)) begin
        rdata <= DW'({PRBS_EN, CSR_EN, 8'(INDEX), 8'(LANES)});
      end else if (CAP_EN && off == OFFW'(`XRA_OFF_USERID)) begin
        rdata <= DW'(USER_ID);
      end else if (CSR_EN && off == OFFW'(`XRA_OFF_STATUS)) begin
        rdata <= DW'(status);
      end else if (CSR_EN && off == OFFW'(`XRA_OFF_CTRL)) begin
        rdata <= DW'(ctrl);
      end else if (off == OFFW'(`XRA_OFF_RATE)) begin
        rdata <= DW'(laneRate);
      end else if (PRBS_EN && off == OFFW'(`XRA_OFF_PRBSBIT)) begin
        rdata <= DW'(bitCount);
      end else if (PRBS_EN && off == OFFW'(`XRA_OFF_PRBSERR)) begin
        rdata <= DW'(errCount);
      end
    end
  end
endmodule : xra_chan

// ---- core/xra_access.sv ----
`include "xra_consts.svh"
module xra_access #(
  parameter int OFFW       = `XRA_OFFW,
  parameter int DW         = `XRA_DW,
  parameter int DEPTH      = `XRA_DEPTH,
  parameter int RATE_W     = `XRA_RATE_W,
  parameter int CNT_W      = `XRA_CNT_W,
  parameter int LANES      = 4,
  parameter bit SHARED     = 1'b1,
  parameter bit SEPARATE   = 1'b0,
  parameter bit DYN_EN     = 1'b1,
  parameter bit DEBUG_EN   = 1'b1,
  parameter bit CAP_EN     = 1'b1,
  parameter bit CSR_EN     = 1'b1,
  parameter bit PRBS_EN    = 1'b1,
  parameter logic [7:0] USER_ID = 8'h00,
  localparam int SELW      = (LANES > 1) ? $clog2(LANES) : 0,
  localparam int SAW       = OFFW + SELW
) (
  input  wire logic [SAW-1:0]          hostAddr,     // shared port address
  input  wire logic                    hostRead,     // shared port read
  input  wire logic                    hostWrite,    // shared port write
  input  wire logic [DW-1:0]           hostWdata,    // shared port write data
  output logic      [DW-1:0]           hostRdata,    // shared port read data
  output logic                         hostWait,     // shared port wait
  input  wire logic [LANES*OFFW-1:0]   chAddr,       // per-channel address slices
  input  wire logic [LANES-1:0]        chRead,       // per-channel read
  input  wire logic [LANES-1:0]        chWrite,      // per-channel write
  input  wire logic [LANES*DW-1:0]     chWdata,      // per-channel write data
  output logic      [LANES*DW-1:0]     chRdata,      // per-channel read data
  output logic      [LANES-1:0]        chWait,       // per-channel wait
  input  wire logic [LANES-1:0]        chReset,      // per-channel reset
  input  wire logic [SAW-1:0]          dbgAddr,      // debug endpoint address
  input  wire logic                    dbgRead,      // debug endpoint read
  input  wire logic                    dbgWrite,     // debug endpoint write
  input  wire logic [DW-1:0]           dbgWdata,     // debug endpoint write data
  output logic      [DW-1:0]           dbgRdata,     // debug endpoint read data
  output logic                         dbgWait,      // debug endpoint wait
  input  wire logic [LANES-1:0]        rx_locked_to_reference, // lock to ref
  input  wire logic [LANES-1:0]        rx_locked_to_data,      // lock to data
  input  wire logic [LANES-1:0]        txCalBusy,    // tx calibration busy
  input  wire logic [LANES-1:0]        rxCalBusy,    // rx calibration busy
  output logic      [LANES-1:0]        serialLoop,   // serial loopback
  output logic      [LANES-1:0]        forceLockData, // force lock to data
  output logic      [LANES-1:0]        forceLockRef, // force lock to ref
  output logic      [LANES-1:0]        txAnalogReset, // tx analog reset
  output logic      [LANES-1:0]        txDigitalReset, // tx digital reset
  output logic      [LANES-1:0]        rxAnalogReset, // rx analog reset
  output logic      [LANES-1:0]        rxDigitalReset, // rx digital reset
  output logic      [LANES*RATE_W-1:0] laneRate,     // lane rate codes
  input  wire logic [LANES-1:0]        prbsBitTick,  // checker bit pulses
  input  wire logic [LANES-1:0]        prbsErrTick,  // checker error pulses
  input  wire logic                    clk,          // 100 MHz clock
  input  wire logic                    reset         // sync reset, high
);
  localparam int  CHW     = (SELW > 0) ? SELW : 1;
  localparam bit  SHR_ON  = SHARED;
  localparam bit  SEP_ON  = SEPARATE && !SHARED;
  localparam bit  DBG_ON  = DEBUG_EN && DYN_EN
                            && (SHARED || LANES == 1);
  localparam int  NP      = SHR_ON ? 1 : LANES;

  logic [CHW-1:0]  hostSel;
  logic [CHW-1:0]  dbgSel;
  logic [LANES-1:0] cAcc;
  logic [LANES-1:0] cWr;
  logic [OFFW-1:0] cOff  [LANES];
  logic [DW-1:0]   cWd   [LANES];
  logic [DW-1:0]   cRd   [LANES];
  logic [LANES-1:0] cRst;
  logic [NP-1:0]   pAcc;
  logic [NP-1:0]   pWr;
  logic [OFFW-1:0] pOff  [NP];
  logic [CHW-1:0]  pSel  [NP];
  logic [DW-1:0]   pWd   [NP];
  logic [DW-1:0]   rdA   [NP];
  logic [DW-1:0]   rdB   [NP];
  logic [NP-1:0]   waitA;
  logic [NP-1:0]   waitB;

  generate
    if (SELW > 0) begin : g_sel
      assign hostSel = hostAddr[SAW-1:OFFW];
      assign dbgSel  = dbgAddr[SAW-1:OFFW];
    end else begin : g_nosel
      assign hostSel = '0;
      assign dbgSel  = '0;
    end
  endgenerate

  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_port
      xra_pkg::xra_port_state_t state;
      logic            reqA;
      logic            wrA;
      logic [OFFW-1:0] offA;
      logic [CHW-1:0]  selA;
      logic [DW-1:0]   wdA;
      logic            reqB;
      logic            useB;
      logic            hit;
      logic            portRst;

      if (SHR_ON) begin : g_shr
        assign reqA = hostRead | hostWrite;
        assign wrA  = hostWrite;
        assign offA = hostAddr[OFFW-1:0];
        assign selA = hostSel;
        assign wdA  = hostWdata;
      end else begin : g_own
        assign reqA = chRead[p] | chWrite[p];
        assign wrA  = chWrite[p];
        assign offA = chAddr[p*OFFW +: OFFW];
        assign selA = CHW'(p);
        assign wdA  = chWdata[p*DW +: DW];
      end
      assign reqB    = (p == 0) && DBG_ON && (dbgRead | dbgWrite);
      assign portRst = SEP_ON ? (reset | chReset[p]) : reset;

      // handshake: wait stays high until the reply cycle
      always_ff @(posedge clk) begin
        if (portRst) begin
          state   <= xra_pkg::XRA_IDLE;
          pAcc[p] <= 1'b0;
          pWr[p]  <= 1'b0;
          pOff[p] <= '0;
          pSel[p] <= '0;
          pWd[p]  <= '0;
          useB    <= 1'b0;
          hit     <= 1'b0;
          waitA[p] <= 1'b1;
          waitB[p] <= 1'b1;
          rdA[p]  <= '0;
          rdB[p]  <= '0;
        end else begin
          pAcc[p] <= 1'b0;
          case (state)
            xra_pkg::XRA_IDLE: begin
              waitA[p] <= 1'b1;
              waitB[p] <= 1'b1;
              if (reqA) begin
                pAcc[p] <= DYN_EN && (32'(selA) < LANES);
                hit     <= DYN_EN && (32'(selA) < LANES);
                pWr[p]  <= wrA;
                pOff[p] <= offA;
                pSel[p] <= selA;
                pWd[p]  <= wdA;
                useB    <= 1'b0;
                state   <= xra_pkg::XRA_ACCESS;
              end else if (reqB) begin
                pAcc[p] <= 32'(dbgSel) < LANES;
                hit     <= 32'(dbgSel) < LANES;
                pWr[p]  <= dbgWrite;
                pOff[p] <= dbgAddr[OFFW-1:0];
                pSel[p] <= dbgSel;
                pWd[p]  <= dbgWdata;
                useB    <= 1'b1;
                state   <= xra_pkg::XRA_ACCESS;
              end
            end
            xra_pkg::XRA_ACCESS: begin
              state <= xra_pkg::XRA_FETCH;
            end
            xra_pkg::XRA_FETCH: begin
              if (useB) begin
                rdB[p]   <= (hit && !pWr[p]) ? cRd[pSel[p]] : '0;
                waitB[p] <= 1'b0;
              end else begin
                rdA[p]   <= (hit && !pWr[p]) ? cRd[pSel[p]] : '0;
                waitA[p] <= 1'b0;
              end
              state <= xra_pkg::XRA_REPLY;
            end
            xra_pkg::XRA_REPLY: begin
              waitA[p] <= 1'b1;
              waitB[p] <= 1'b1;
              state    <= xra_pkg::XRA_IDLE;
            end
            default: begin
              state <= xra_pkg::XRA_IDLE;
            end
          endcase
        end
      end
    end
  endgenerate

  generate
    if (SHR_ON) begin : g_out_shr
      assign hostRdata = rdA[0];
      assign hostWait  = waitA[0];
      assign chRdata   = '0;
      assign chWait    = '0;
    end else begin : g_out_own
      assign hostRdata = '0;
      assign hostWait  = 1'b0;
      for (p = 0; p < LANES; p++) begin : g_ch
        assign chRdata[p*DW +: DW] = rdA[p];
        assign chWait[p]           = waitA[p];
      end
    end
  endgenerate
  assign dbgRdata = rdB[0];
  assign dbgWait  = DBG_ON ? waitB[0] : 1'b0;

  genvar c;
  generate
    for (c = 0; c < LANES; c++) begin : g_chan
      logic [`XRA_CTRL_W-1:0] ctrl;
      if (SHR_ON) begin : g_mux
        assign cAcc[c] = pAcc[0] && (32'(pSel[0]) == c);
        assign cWr[c]  = pWr[0];
        assign cOff[c] = pOff[0];
        assign cWd[c]  = pWd[0];
      end else begin : g_direct
        assign cAcc[c] = pAcc[c];
        assign cWr[c]  = pWr[c];
        assign cOff[c] = pOff[c];
        assign cWd[c]  = pWd[c];
      end
      assign cRst[c] = SEP_ON ? (reset | chReset[c]) : reset;

      xra_chan #(
        .OFFW    (OFFW),
        .DW      (DW),
        .DEPTH   (DEPTH),
        .RATE_W  (RATE_W),
        .CNT_W   (CNT_W),
        .LANES   (LANES),
        .INDEX   (c),
        .CAP_EN  (CAP_EN),
        .CSR_EN  (CSR_EN),
        .PRBS_EN (PRBS_EN),
        .USER_ID (USER_ID)
      ) u_chan (
        .clk      (clk),
        .reset    (cRst[c]),
        .acc      (cAcc[c]),
        .wr       (cWr[c]),
        .off      (cOff[c]),
        .wdata    (cWd[c]),
        .rdata    (cRd[c]),
        .status   ({rxCalBusy[c], txCalBusy[c],
                    rx_locked_to_data[c], rx_locked_to_reference[c]}),
        .ctrl     (ctrl),
        .laneRate (laneRate[c*RATE_W +: RATE_W]),
        .bitTick  (prbsBitTick[c]),
        .errTick  (prbsErrTick[c])
      );

      assign serialLoop[c]     = ctrl[`XRA_CTRL_LOOP];
      assign forceLockData[c]  = ctrl[`XRA_CTRL_FDATA];
      assign forceLockRef[c]   = ctrl[`XRA_CTRL_FREF];
      assign txAnalogReset[c]  = ctrl[`XRA_CTRL_TXAR];
      assign txDigitalReset[c] = ctrl[`XRA_CTRL_TXDR];
      assign rxAnalogReset[c]  = ctrl[`XRA_CTRL_RXAR];
      assign rxDigitalReset[c] = ctrl[`XRA_CTRL_RXDR];
    end
  endgenerate
endmodule : xra_access

// ---- test/xra_access_assertions.sv ----
`include "xra_consts.svh"
module xra_access_checker #(
  parameter int         LANES   = 4,
  parameter logic [7:0] USER_ID = 8'h00,
  localparam int        SAW     = `XRA_OFFW + ((LANES > 1) ? $clog2(LANES) : 0)
) (
  input wire logic               clk,                    // clock
  input wire logic               reset,                  // sync reset
  input wire logic [SAW-1:0]     hostAddr,               // address
  input wire logic               hostRead,               // read
  input wire logic               hostWrite,              // write
  input wire logic [31:0]        hostWdata,              // write data
  input wire logic [31:0]        hostRdata,              // read data
  input wire logic               hostWait,               // wait
  input wire logic               dbgRead,                // debug read
  input wire logic               dbgWrite,               // debug write
  input wire logic               dbgWait,                // debug wait
  input wire logic [LANES-1:0]   serialLoop,             // loopback
  input wire logic [LANES-1:0]   txAnalogReset,          // tx analog reset
  input wire logic [LANES*8-1:0] laneRate,               // rate codes
  input wire logic [LANES-1:0]   rx_locked_to_reference, // lock ref
  input wire logic [LANES-1:0]   rx_locked_to_data,      // lock data
  input wire logic [LANES-1:0]   txCalBusy,              // tx cal
  input wire logic [LANES-1:0]   rxCalBusy               // rx cal
);
  logic [SAW-1:0] ch;
  logic [9:0]     off;
  logic           rdRep;
  logic           wrRep;
  assign ch    = hostAddr >> `XRA_OFFW;
  assign off   = hostAddr[`XRA_OFFW-1:0];
  assign rdRep = hostRead && !hostWait;
  assign wrRep = hostWrite && !hostWait && ch < LANES;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_reset_idle: assert property (
    $fell(reset) |-> hostWait && serialLoop == '0 && laneRate == '0)
    else $error("outputs not idle after reset");
  chk_reply_latency: assert property (
    $rose(hostRead || hostWrite) && hostWait |-> hostWait[*3] ##1 !hostWait)
    else $error("host reply not at third edge");
  chk_reply_single: assert property (!hostWait |=> hostWait)
    else $error("host reply longer than one cycle");
  chk_dbg_reply: assert property ($rose(dbgRead || dbgWrite) |-> ##[3:12] !dbgWait)
    else $error("debug access not answered");
  chk_ctrl_write: assert property (
    wrRep && off == `XRA_OFF_CTRL |->
      serialLoop[ch] == hostWdata[0] && txAnalogReset[ch] == hostWdata[3])
    else $error("control outputs do not follow write");
  chk_rate_write: assert property (
    wrRep && off == `XRA_OFF_RATE |-> laneRate[ch*8 +: 8] == hostWdata[7:0])
    else $error("lane rate does not follow write");
  chk_status_read: assert property (
    rdRep && ch < LANES && off == `XRA_OFF_STATUS |-> hostRdata == {28'h0, rxCalBusy[ch],
      txCalBusy[ch], rx_locked_to_data[ch], rx_locked_to_reference[ch]})
    else $error("status read mismatch");
  chk_capid_read: assert property (
    rdRep && ch < LANES && off == `XRA_OFF_CAPID |-> hostRdata == `XRA_CAP_ID)
    else $error("capability id read mismatch");
  chk_userid_read: assert property (
    rdRep && ch < LANES && off == `XRA_OFF_USERID |-> hostRdata == {24'h0, USER_ID})
    else $error("user identifier read mismatch");
  chk_bad_channel: assert property (rdRep && ch >= LANES |-> hostRdata == '0)
    else $error("absent channel read not zero");
endmodule : xra_access_checker

// ---- test/xra_host_model.sv ----
module xra_host_model #(
  parameter int SAW = 12
) (
  input  wire logic            clk,       // clock
  output logic      [SAW-1:0]  hostAddr,  // address
  output logic                 hostRead,  // read
  output logic                 hostWrite, // write
  output logic      [31:0]     hostWdata, // write data
  input  wire logic [31:0]     hostRdata, // read data
  input  wire logic            hostWait   // wait
);
  timeunit 1ns;
  timeprecision 100ps;
  int hangs = 0;
  initial begin
    hostAddr = '0;
    hostRead = 1'b0;
    hostWrite = 1'b0;
    hostWdata = '0;
  end
  // one access at a time, held until wait is sampled low
  task automatic access(input logic wr, input logic [SAW-1:0] a, input logic [31:0] d,
                        input int slow, output logic [31:0] q);
    int n;
    n = 0;
    repeat (slow + 1) @(posedge clk);
    #1;
    hostAddr = a;
    hostWdata = d;
    hostWrite = wr;
    hostRead = !wr;
    do begin
      @(posedge clk);
      n++;
    end while (hostWait !== 1'b0 && n < 20);
    q = hostRdata;
    if (n >= 20) hangs++;
    #1;
    hostRead = 1'b0;
    hostWrite = 1'b0;
    hostAddr = ~a;
    hostWdata = ~d;
  endtask : access
endmodule : xra_host_model

// ---- test/testbench.sv ----
`include "xra_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int         LANES   = 3;
  localparam int         SAW     = 12;
  localparam logic [7:0] USER_ID = 8'hA7;
  logic              clk, reset, hostRead, hostWrite, hostWait, dbgRead, dbgWrite, dbgWait;
  logic [SAW-1:0]    hostAddr, dbgAddr;
  logic [31:0]       hostWdata, hostRdata, dbgWdata, dbgRdata, q, d;
  logic [LANES-1:0]  lockRef, lockData, txCal, rxCal, bitTick, errTick;
  logic [LANES-1:0]  ctrlOut [7];
  logic [LANES*8-1:0] laneRate;
  int                seed, failures, compares, c, n, m;
  xra_access #(.LANES(LANES), .USER_ID(USER_ID)) u_dut (
    .hostAddr(hostAddr), .hostRead(hostRead), .hostWrite(hostWrite), .hostWdata(hostWdata),
    .hostRdata(hostRdata), .hostWait(hostWait), .chAddr('0), .chRead('0), .chWrite('0),
    .chWdata('0), .chRdata(), .chWait(), .chReset('0), .dbgAddr(dbgAddr), .dbgRead(dbgRead),
    .dbgWrite(dbgWrite), .dbgWdata(dbgWdata), .dbgRdata(dbgRdata), .dbgWait(dbgWait),
    .rx_locked_to_reference(lockRef), .rx_locked_to_data(lockData), .txCalBusy(txCal),
    .rxCalBusy(rxCal), .serialLoop(ctrlOut[0]), .forceLockData(ctrlOut[1]),
    .forceLockRef(ctrlOut[2]), .txAnalogReset(ctrlOut[3]), .txDigitalReset(ctrlOut[4]),
    .rxAnalogReset(ctrlOut[5]), .rxDigitalReset(ctrlOut[6]), .laneRate(laneRate),
    .prbsBitTick(bitTick), .prbsErrTick(errTick), .clk(clk), .reset(reset));
  xra_host_model #(.SAW(SAW)) u_host (.clk(clk), .hostAddr(hostAddr), .hostRead(hostRead),
    .hostWrite(hostWrite), .hostWdata(hostWdata), .hostRdata(hostRdata), .hostWait(hostWait));
  function automatic logic [SAW-1:0] adr(input int ch, input logic [9:0] off);
    return {ch[1:0], off};
  endfunction : adr
  function automatic logic [31:0] capcfg(input int ch);
    return {14'h0, 2'b11, ch[7:0], 8'(LANES)};
  endfunction : capcfg
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input int ch, input logic [9:0] off, input logic [31:0] v);
    u_host.access(1'b1, adr(ch, off), v, ch, q);
  endtask : wr
  task automatic rd(input int ch, input logic [9:0] off);
    u_host.access(1'b0, adr(ch, off), 32'h0, 0, q);
  endtask : rd
  task automatic dbg(input logic w, input logic [SAW-1:0] a, input logic [31:0] v);
    int k;
    k = 0;
    @(posedge clk);
    #1;
    {dbgAddr, dbgWdata, dbgWrite, dbgRead} = {a, v, w, !w};
    do begin
      @(posedge clk);
      k++;
    end while (dbgWait !== 1'b0 && k < 20);
    q = dbgRdata;
    if (k >= 20) failures++;
    #1;
    {dbgAddr, dbgWrite, dbgRead, dbgWdata} = {~a, 2'b00, ~v};
  endtask : dbg
  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100us;
    failures++;
    end_of_test();
  end
  initial begin
    seed = 43200;
    {failures, compares} = '0;
    {dbgAddr, dbgRead, dbgWrite, dbgWdata} = '0;
    {lockRef, lockData, txCal, rxCal, bitTick, errTick} = '0;
    reset = 1'b1;
    repeat (5) @(posedge clk);
    #1 reset = 1'b0;
    check(hostWait, 1'b1);
    check(laneRate, '0);
    for (int b = 0; b < 7; b++) check(ctrlOut[b], '0);
    for (c = 0; c < LANES; c++) begin
      rd(c, `XRA_OFF_CAPID); check(q, `XRA_CAP_ID);
      wr(c, `XRA_OFF_CAPCFG, 32'hFFFF_FFFF);
      rd(c, `XRA_OFF_CAPCFG); check(q, capcfg(c));
      rd(c, `XRA_OFF_USERID); check(q, {24'h0, USER_ID});
    end
    for (int i = 0; i < 10; i++) begin
      c = (i == 0) ? LANES - 1 : $unsigned($random(seed)) % LANES;
      n = (i == 0) ? 63 : $unsigned($random(seed)) % 64;
      d = $random(seed);
      wr(c, n[9:0], d);
      wr((c + 1) % LANES, n[9:0], ~d);
      rd(c, n[9:0]); check(q, d);
      rd((c + 1) % LANES, n[9:0]); check(q, ~d);
    end
    wr(3, 10'h005, 32'h1234_5678);
    rd(3, 10'h005); check(q, 32'h0);
    for (c = 0; c < LANES; c++) begin
      d = $random(seed);
      {lockRef[c], lockData[c], txCal[c], rxCal[c]} = d[3:0];
      rd(c, `XRA_OFF_STATUS); check(q, {28'h0, d[0], d[1], d[2], d[3]});
      wr(c, `XRA_OFF_CTRL, {25'h0, d[10:4]});
      for (int b = 0; b < 7; b++) check(ctrlOut[b][c], d[4+b]);
      rd(c, `XRA_OFF_CTRL); check(q, {25'h0, d[10:4]});
      wr(c, `XRA_OFF_RATE, {24'h0, d[31:24]});
      check(laneRate[c*8 +: 8], d[31:24]);
      rd(c, `XRA_OFF_RATE); check(q, {24'h0, d[31:24]});
      wr(c, `XRA_OFF_PRBSCTL, 32'h1);
      n = 1 + $unsigned($random(seed)) % 20;
      m = $unsigned($random(seed)) % (n + 1);
      for (int i = 0; i <= n; i++) begin
        @(posedge clk);
        #1;
        bitTick[c] = i < n;
        errTick[c] = i < m;
      end
      rd(c, `XRA_OFF_PRBSBIT); check(q, n);
      rd(c, `XRA_OFF_PRBSERR); check(q, m);
      wr(c, `XRA_OFF_PRBSCTL, 32'h1);
      rd(c, `XRA_OFF_PRBSBIT); check(q, 32'h0);
    end
    // mid-run reset clears control and rate outputs
    @(posedge clk);
    #1 reset = 1'b1;
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    check(hostWait, 1'b1);
    check(laneRate, '0);
    for (int b = 0; b < 7; b++) check(ctrlOut[b], '0);
    fork
      u_host.access(1'b1, adr(0, 10'h005), 32'hA5A5_0001, 0, d);
      dbg(1'b1, adr(2, 10'h006), 32'h5A5A_0002);
    join
    dbg(1'b0, adr(0, 10'h005), 32'h0); check(q, 32'hA5A5_0001);
    rd(2, 10'h006); check(q, 32'h5A5A_0002);
    dbg(1'b0, adr(1, `XRA_OFF_CAPID), 32'h0); check(q, `XRA_CAP_ID);
    check(u_host.hangs, 32'h0);
    end_of_test();
  end
endmodule : testbench
bind xra_access xra_access_checker #(.LANES(LANES), .USER_ID(USER_ID)) u_chk (
  .clk(clk), .reset(reset), .hostAddr(hostAddr), .hostRead(hostRead), .hostWrite(hostWrite),
  .hostWdata(hostWdata), .hostRdata(hostRdata), .hostWait(hostWait), .dbgRead(dbgRead),
  .dbgWrite(dbgWrite), .dbgWait(dbgWait), .serialLoop(serialLoop),
  .txAnalogReset(txAnalogReset), .laneRate(laneRate),
  .rx_locked_to_reference(rx_locked_to_reference), .rx_locked_to_data(rx_locked_to_data),
  .txCalBusy(txCalBusy), .rxCalBusy(rxCalBusy));
